/* rtl/pot_eeprom_pkg.sv */
// constants, enumerations and carriers shared by the pot/eeprom slave
// assumes a 100 MHz reference clock and a serial clock far below it
package pot_eeprom_pkg;
  localparam int ADDR_W = 11;
  localparam int MEM_DEPTH = 2048;
  localparam int WIPER_W = 7;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 4;
  localparam int TIMER_W = 21;
  localparam int PAGE_LSB_W = 4;

  // bit slots of the last data bit and of the acknowledge within a byte frame
  localparam logic [CNT_W-1:0] LAST_DATA_BIT = 4'h7;
  localparam logic [CNT_W-1:0] ACK_SLOT = 4'h8;

  // memory map byte addresses
  localparam logic [ADDR_W-1:0] GP_LAST_ADDR = 11'h7FB;
  localparam logic [ADDR_W-1:0] RSVD_A_ADDR = 11'h7FC;
  localparam logic [ADDR_W-1:0] RSVD_B_ADDR = 11'h7FD;
  localparam logic [ADDR_W-1:0] ACCESS_CTRL_ADDR = 11'h7FE;
  localparam logic [ADDR_W-1:0] WIPER_PORT_ADDR = 11'h7FF;

  // reset values
  localparam logic [WIPER_W-1:0] WIPER_RESET = 7'h40;
  localparam logic VOLATILE_ONLY_RESET = 1'b0;

  // device-type code; the value is arbitrary
  localparam logic [3:0] DEVICE_TYPE_CODE = 4'h6;

  // timing
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int NV_WRITE_CYCLE_TIME_MS = 12;
  localparam int POWER_UP_TIME_MS = 3;
  // longest times, rounded down
  localparam int NV_WRITE_CYCLES = NV_WRITE_CYCLE_TIME_MS * CLK_FREQ_KHZ;
  localparam int POWER_UP_CYCLES = POWER_UP_TIME_MS * CLK_FREQ_KHZ;

  typedef enum logic [3:0] {
    ST_PWRUP,
    ST_LOAD,
    ST_IDLE,
    ST_ID,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_NVW
  } link_state_e;

  // sampled bit handed from the serial clock domain
  typedef struct packed {
    logic bit_val;
    logic tog;
  } bit_sample_s;

  // synchronised pin levels
  typedef struct packed {
    logic scl;
    logic sda;
    logic wp_n;
  } pin_level_s;
endpackage

/* rtl/sync2.sv */
// two-stage level synchroniser into the clock of its user
// assumes the input holds each level for more than a clock period
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

/* rtl/link_bit_capture.sv */
// samples the data line on each rising serial clock edge
// assumes the serial clock runs during reset so the link reset lands
module link_bit_capture
  import pot_eeprom_pkg::*;
(
  input wire logic link_clk_in,
  input wire logic srst_in,
  input wire logic sda_in,
  output pot_eeprom_pkg::bit_sample_s sample_out
);
  bit_sample_s state_ff;
  bit_sample_s nxt_state;
  logic link_rst;

  sync2 #(.WIDTH(1)) u_rst_sync (
    .clk_in(link_clk_in),
    .ce_in(1'b1),
    .async_in(srst_in),
    .sync_out(link_rst)
  );

  // every bit is taken on the rising clock; the toggle marks a new bit
  always_comb begin
    nxt_state = state_ff;
    nxt_state.bit_val = sda_in;
    nxt_state.tog = ~state_ff.tog;
  end

  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sample_out = state_ff;
endmodule

/* rtl/i2c_pot_eeprom_slave.sv */
// serial slave front end of a digital pot with 2048-byte memory
// assumes an external master drives the serial clock and wires the
// data line open drain; the serial clock is fed to link_clk_in
//
// Operation
// - wiper held in 7-bit volatile register
// - wiper forced to 40 hex at power-up
// - stored initial value copied into wiper after power-up
// - 2048 bytes addressed 000 to 7FF
// - access-select flag at 7FE msb, cleared at power-up
// - 7FF read gives wiper or stored value
// - 7FF write: wiper only, or both
// - select and wiper bytes, one or two writes
// - msb first, device is slave only
// - start and stop detected while clock high
// - data pin released until a start is seen
// - starts ignored during power-up and write cycle
// - stop goes standby or launches write cycle
// - receiver pulls data low in ninth clock
// - ack identification, address and write data bytes
// - id byte: type code, A10-A8, direction
// - 11-bit address from id and address bytes
// - write cycle completes within 12 ms
// - write-protect low blocks all writes
// - read pointer increments per byte sent
module i2c_pot_eeprom_slave
  import pot_eeprom_pkg::*;
#(
  parameter int unsigned NV_WRITE_LEN = NV_WRITE_CYCLES,
  parameter int unsigned POWER_UP_LEN = POWER_UP_CYCLES,
  parameter logic [3:0] TYPE_CODE = DEVICE_TYPE_CODE
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic link_clk_in,
  input wire logic sda_in,
  input wire logic wp_n_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic [pot_eeprom_pkg::WIPER_W-1:0] digital_pot_out,
  output logic nv_busy_out,
  output logic volatile_only_flag_out
);
  typedef struct packed {
    link_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [BYTE_W-1:0] shift;
    logic [BYTE_W-1:0] tx;
    logic [ADDR_W-1:0] ptr;
    logic read_not_write;
    logic ack;
    logic nv_pend;
    logic volatile_only_flag;
    logic [WIPER_W-1:0] wiper;
    logic oe;
    logic sda_lvl;
    logic busy;
    logic [TIMER_W-1:0] timer;
    logic tog_q;
    logic scl_q;
    logic sda_q;
  } ctl_s;

  ctl_s state_ff;
  ctl_s nxt_state;

  // non-volatile array; holds its contents across reset
  logic [BYTE_W-1:0] mem [MEM_DEPTH];

  bit_sample_s link_sample;
  logic tog_sync;
  pin_level_s pin_raw;
  pin_level_s pin_sync;
  logic [BYTE_W-1:0] mem_rd;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [BYTE_W-1:0] mem_wd;
  logic start_det;
  logic stop_det;
  logic bit_evt;
  logic scl_fall;
  logic [BYTE_W-1:0] byte_in;
  logic in_frame;
  logic busy_internal;

  // byte that the master sees at a given address
  function automatic logic [BYTE_W-1:0] read_byte(
    input logic [ADDR_W-1:0] addr,
    input logic [BYTE_W-1:0] word,
    input logic flag,
    input logic [WIPER_W-1:0] wiper
  );
    logic [BYTE_W-1:0] res;
    res = word;
    if (addr == ACCESS_CTRL_ADDR) begin
      res = {flag, 7'h00};
    end else if (addr == WIPER_PORT_ADDR && flag) begin
      res = {1'b0, wiper};
    end
    return res;
  endfunction

  link_bit_capture u_capture (
    .link_clk_in(link_clk_in),
    .srst_in(srst_in),
    .sda_in(sda_in),
    .sample_out(link_sample)
  );

  sync2 #(.WIDTH(1)) u_tog_sync (
    .clk_in(ref_clk_in),
    .ce_in(ce_in),
    .async_in(link_sample.tog),
    .sync_out(tog_sync)
  );

  // serial clock also watched as a level for start and stop
  assign pin_raw = '{scl: link_clk_in, sda: sda_in, wp_n: wp_n_in};

  sync2 #(.WIDTH(3)) u_pin_sync (
    .clk_in(ref_clk_in),
    .ce_in(ce_in),
    .async_in(pin_raw),
    .sync_out(pin_sync)
  );

  // asynchronous read from the registered pointer
  assign mem_rd = mem[state_ff.ptr];

  // one pass per reference cycle; bus conditions last
  always_comb begin
    nxt_state = state_ff;
    mem_we = 1'b0;
    mem_wa = state_ff.ptr;
    mem_wd = '0;
    nxt_state.scl_q = pin_sync.scl;
    nxt_state.sda_q = pin_sync.sda;
    nxt_state.tog_q = tog_sync;
    nxt_state.sda_lvl = 1'b0;
    start_det = pin_sync.scl & state_ff.scl_q & state_ff.sda_q
      & ~pin_sync.sda;
    stop_det = pin_sync.scl & state_ff.scl_q & ~state_ff.sda_q
      & pin_sync.sda;
    bit_evt = tog_sync ^ state_ff.tog_q;
    scl_fall = state_ff.scl_q & ~pin_sync.scl;
    // the captured bit is stable once its toggle has been synchronised
    byte_in = {state_ff.shift[BYTE_W-2:0], link_sample.bit_val};
    in_frame = 1'b0;
    busy_internal = 1'b0;

    unique case (state_ff.st)
      ST_PWRUP: begin
        busy_internal = 1'b1;
        nxt_state.wiper = WIPER_RESET;
        if (state_ff.timer == TIMER_W'(POWER_UP_LEN - 1)) begin
          nxt_state.st = ST_LOAD;
          nxt_state.timer = '0;
        end else begin
          nxt_state.timer = state_ff.timer + 1'b1;
        end
      end
      ST_LOAD: begin
        // first cycle points at the stored value, second copies it
        busy_internal = 1'b1;
        nxt_state.ptr = WIPER_PORT_ADDR;
        if (state_ff.ptr == WIPER_PORT_ADDR) begin
          nxt_state.wiper = mem_rd[WIPER_W-1:0];
          nxt_state.st = ST_IDLE;
        end
      end
      ST_NVW: begin
        busy_internal = 1'b1;
        if (state_ff.timer == TIMER_W'(NV_WRITE_LEN - 1)) begin
          nxt_state.st = ST_IDLE;
          nxt_state.timer = '0;
        end else begin
          nxt_state.timer = state_ff.timer + 1'b1;
        end
      end
      ST_IDLE: begin
        nxt_state.ack = 1'b0;
      end
      ST_ID, ST_ADDR, ST_WDATA: begin
        in_frame = 1'b1;
        if (bit_evt) begin
          if (state_ff.cnt == ACK_SLOT) begin
            nxt_state.cnt = '0;
            nxt_state.ack = 1'b0;
            if (state_ff.st == ST_ID) begin
              if (state_ff.read_not_write) begin
                nxt_state.st = ST_RDATA;
                nxt_state.tx = read_byte(state_ff.ptr, mem_rd,
                  state_ff.volatile_only_flag, state_ff.wiper);
              end else begin
                nxt_state.st = ST_ADDR;
              end
            end else if (state_ff.st == ST_ADDR) begin
              nxt_state.st = ST_WDATA;
            end
          end else begin
            nxt_state.shift = byte_in;
            nxt_state.cnt = state_ff.cnt + 1'b1;
            if (state_ff.cnt == LAST_DATA_BIT) begin
              unique case (state_ff.st)
                ST_ID: begin
                  if (byte_in[7:4] == TYPE_CODE) begin
                    nxt_state.ptr[ADDR_W-1:BYTE_W] = byte_in[3:1];
                    nxt_state.read_not_write = byte_in[0];
                    nxt_state.ack = 1'b1;
                  end else begin
                    nxt_state.st = ST_IDLE;
                  end
                end
                ST_ADDR: begin
                  nxt_state.ptr[BYTE_W-1:0] = byte_in;
                  nxt_state.ack = 1'b1;
                end
                default: begin
                  if (!pin_sync.wp_n) begin
                    nxt_state.st = ST_IDLE;
                  end else begin
                    nxt_state.ack = 1'b1;
                    // writes wrap inside the current page
                    nxt_state.ptr[PAGE_LSB_W-1:0] =
                      state_ff.ptr[PAGE_LSB_W-1:0] + 1'b1;
                    if (state_ff.ptr == ACCESS_CTRL_ADDR) begin
                      nxt_state.volatile_only_flag = byte_in[7];
                    end else if (state_ff.ptr == WIPER_PORT_ADDR) begin
                      nxt_state.wiper = byte_in[WIPER_W-1:0];
                      if (!state_ff.volatile_only_flag) begin
                        mem_we = 1'b1;
                        nxt_state.nv_pend = 1'b1;
                      end
                    end else begin
                      mem_we = 1'b1;
                      nxt_state.nv_pend = 1'b1;
                    end
                    mem_wd = byte_in;
                  end
                end
              endcase
            end
          end
        end
      end
      ST_RDATA: begin
        in_frame = 1'b1;
        if (bit_evt) begin
          if (state_ff.cnt == ACK_SLOT) begin
            if (!link_sample.bit_val) begin
              nxt_state.cnt = '0;
              nxt_state.tx = read_byte(state_ff.ptr, mem_rd,
                state_ff.volatile_only_flag, state_ff.wiper);
            end else begin
              nxt_state.st = ST_IDLE;
            end
          end else begin
            nxt_state.cnt = state_ff.cnt + 1'b1;
            if (state_ff.cnt == LAST_DATA_BIT) begin
              nxt_state.ptr = state_ff.ptr + 1'b1;
            end
          end
        end
      end
      default: begin
        nxt_state.st = ST_IDLE;
      end
    endcase

    // start and stop win over a bit handled in the same cycle
    if (start_det && !busy_internal) begin
      nxt_state.st = ST_ID;
      nxt_state.cnt = '0;
      nxt_state.ack = 1'b0;
      nxt_state.oe = 1'b0;
    end else if (stop_det && (in_frame || state_ff.st == ST_IDLE)) begin
      nxt_state.ack = 1'b0;
      nxt_state.oe = 1'b0;
      nxt_state.timer = '0;
      if (state_ff.nv_pend || nxt_state.nv_pend) begin
        nxt_state.st = ST_NVW;
      end else begin
        nxt_state.st = ST_IDLE;
      end
      nxt_state.nv_pend = 1'b0;
    end else if (scl_fall) begin
      if (state_ff.st == ST_RDATA && state_ff.cnt < ACK_SLOT) begin
        nxt_state.oe = ~state_ff.tx[3'd7 - state_ff.cnt[2:0]];
      end else if (state_ff.st == ST_ID || state_ff.st == ST_ADDR
          || state_ff.st == ST_WDATA) begin
        nxt_state.oe = state_ff.ack;
      end else begin
        nxt_state.oe = 1'b0;
      end
    end
    // follows the next state so the busy output is a flop
    nxt_state.busy = (nxt_state.st == ST_PWRUP) || (nxt_state.st == ST_LOAD)
      || (nxt_state.st == ST_NVW);
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_ff <= '{
        st: ST_PWRUP,
        cnt: '0,
        shift: '0,
        tx: '0,
        ptr: '0,
        read_not_write: 1'b0,
        ack: 1'b0,
        nv_pend: 1'b0,
        volatile_only_flag: VOLATILE_ONLY_RESET,
        wiper: WIPER_RESET,
        oe: 1'b0,
        sda_lvl: 1'b0,
        busy: 1'b1,
        timer: '0,
        tog_q: 1'b0,
        scl_q: 1'b1,
        sda_q: 1'b1
      };
    end else if (ce_in) begin
      state_ff <= nxt_state;
    end
  end

  // memory has no reset so stored values survive it
  always_ff @(posedge ref_clk_in) begin
    if (ce_in && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign sda_out = state_ff.sda_lvl;
  assign sda_oe_out = state_ff.oe;
  assign digital_pot_out = state_ff.wiper;
  assign nv_busy_out = state_ff.busy;
  assign volatile_only_flag_out = state_ff.volatile_only_flag;
endmodule

/* tb/i2c_pot_eeprom_slave_props.sv */
// concurrent checks on the pot/eeprom slave ports
// assumes one reference clock domain with synchronous reset
module i2c_pot_eeprom_slave_props
  import pot_eeprom_pkg::*;
#(
  parameter int unsigned NV_WRITE_LEN = NV_WRITE_CYCLES,
  parameter int unsigned POWER_UP_LEN = POWER_UP_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic link_clk_in,
  input wire logic sda_in,
  input wire logic wp_n_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [pot_eeprom_pkg::WIPER_W-1:0] digital_pot_out,
  input wire logic nv_busy_out,
  input wire logic volatile_only_flag_out
);
  import pot_eeprom_pkg::*;
  int unsigned busy_cnt_ff;

  // running cycles of the current busy stretch; frozen cycles not counted
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !nv_busy_out) begin
      busy_cnt_ff <= 0;
    end else if (ce_in) begin
      busy_cnt_ff <= busy_cnt_ff + 1;
    end
  end

  default clocking ck @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  chk_drive_only_low: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  chk_reset_wiper: assert property ($fell(srst_in) |->
    (digital_pot_out == WIPER_RESET) [*8])
    else $error("wiper not held at reset value");
  chk_reset_flag: assert property ($fell(srst_in) |->
    volatile_only_flag_out == VOLATILE_ONLY_RESET && !sda_oe_out)
    else $error("flag or data drive wrong after reset");
  chk_powerup_busy: assert property ($fell(srst_in) |->
    nv_busy_out [*8])
    else $error("power-up delay too short");
  chk_busy_quiet: assert property (nv_busy_out |-> !sda_oe_out)
    else $error("data line driven while busy");
  chk_oe_scl_low: assert property (!$stable(sda_oe_out) |->
    !link_clk_in)
    else $error("data drive changed with clock high");
  chk_wp_guard: assert property (!$stable(digital_pot_out) &&
    !nv_busy_out |-> wp_n_in)
    else $error("wiper changed while protected");
  chk_cycle_min: assert property ($rose(nv_busy_out) |->
    nv_busy_out [*8])
    else $error("write cycle too short");
  chk_cycle_bound: assert property (
    busy_cnt_ff <= POWER_UP_LEN + NV_WRITE_LEN + 4)
    else $error("busy stretch too long");
endmodule

bind i2c_pot_eeprom_slave i2c_pot_eeprom_slave_props #(
  .NV_WRITE_LEN(NV_WRITE_LEN),
  .POWER_UP_LEN(POWER_UP_LEN)
) props (
  .ref_clk_in(ref_clk_in), .srst_in(srst_in), .ce_in(ce_in),
  .link_clk_in(link_clk_in), .sda_in(sda_in), .wp_n_in(wp_n_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .digital_pot_out(digital_pot_out), .nv_busy_out(nv_busy_out),
  .volatile_only_flag_out(volatile_only_flag_out)
);

/* tb/i2c_master_model.sv */
// serial bus master model driving clock and open-drain data
// assumes a pull-up on the data line, so released data reads high
module i2c_master_model #(
  parameter int HALF = 120
) (
  output logic scl_out,
  output logic sda_low_out,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // free clock only around a reset, outside any frame
  task automatic run_reset_clock(input int n);
    repeat (n) begin
      #15 scl_out = 1'b0;
      #15 scl_out = 1'b1;
    end
  endtask
  task automatic start_cond();
    #(HALF / 2) sda_low_out = 1'b0;
    #(HALF / 2) scl_out = 1'b1;
    #HALF sda_low_out = 1'b1;
    #HALF scl_out = 1'b0;
  endtask
  task automatic stop_cond();
    #(HALF / 2) sda_low_out = 1'b1;
    #(HALF / 2) scl_out = 1'b1;
    #HALF sda_low_out = 1'b0;
    #HALF;
  endtask
  task automatic clock_bit(input logic b, output logic s);
    #(HALF / 2) sda_low_out = ~b;
    #(HALF / 2) scl_out = 1'b1;
    s = sda_in;
    #HALF scl_out = 1'b0;
  endtask
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
    clock_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
    clock_bit(~ack, s);
  endtask
endmodule

/* tb/i2c_pot_eeprom_slave_tb.sv */
// self-checking bench for the pot/eeprom serial slave
// assumes the master model owns the serial clock and data line
module i2c_pot_eeprom_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pot_eeprom_pkg::*;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic wp_n_in = 1'b1;
  logic scl, m_low, sda, sda_out, sda_oe_out, nv_busy_out, flag, k;
  logic [WIPER_W-1:0] pot;
  logic [3:0] acks;
  logic [7:0] rq [2];
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;

  always #5 ref_clk_in = ~ref_clk_in;
  assign sda = (sda_oe_out && !sda_out) || m_low ? 1'b0 : 1'b1;

  i2c_master_model m (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));
  i2c_pot_eeprom_slave #(.NV_WRITE_LEN(200), .POWER_UP_LEN(10)) dut (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .link_clk_in(scl), .sda_in(sda), .wp_n_in(wp_n_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .digital_pot_out(pot), .nv_busy_out(nv_busy_out),
    .volatile_only_flag_out(flag));

  task automatic report_and_stop();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d0,
                    input logic [7:0] d1, input int n);
    acks = 4'h0;
    @(posedge ref_clk_in);
    #2 m.start_cond();
    m.write_byte({DEVICE_TYPE_CODE, a[10:8], 1'b0}, acks[0]);
    m.write_byte(a[7:0], acks[1]);
    m.write_byte(d0, acks[2]);
    if (n > 1) m.write_byte(d1, acks[3]);
    m.stop_cond();
  endtask
  task automatic rd(input logic [10:0] a, input int n);
    logic k0;
    @(posedge ref_clk_in);
    #2 m.start_cond();
    m.write_byte({DEVICE_TYPE_CODE, a[10:8], 1'b0}, k0);
    m.write_byte(a[7:0], k0);
    m.start_cond();
    m.write_byte({DEVICE_TYPE_CODE, a[10:8], 1'b1}, k0);
    for (int i = 0; i < n; i++) m.read_byte(i < n - 1, rq[i]);
    m.stop_cond();
  endtask
  task automatic id_only(input logic [3:0] code);
    @(posedge ref_clk_in);
    #2 m.start_cond();
    m.write_byte({code, 4'hE}, k);
    m.stop_cond();
  endtask
  task automatic wait_idle();
    int t;
    t = 0;
    while (nv_busy_out !== 1'b0 && t < 2000) begin
      @(posedge ref_clk_in);
      #2;
      t++;
    end
    chk({7'h00, nv_busy_out}, 8'h00);
  endtask
  task automatic do_reset();
    @(posedge ref_clk_in);
    srst_in <= 1'b1;
    #2 m.run_reset_clock(4);
    chk({1'b0, pot}, {1'b0, WIPER_RESET});
    chk({7'h00, flag}, 8'h00);
    chk({6'h00, nv_busy_out, sda_oe_out}, 8'h02);
    @(posedge ref_clk_in);
    srst_in <= 1'b0;
    // link-side reset leaves only on serial clock edges
    #2 m.run_reset_clock(3);
  endtask

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    do_reset();
    wait_idle();
    wr(11'h7FF, 8'h25, 8'h00, 1);
    chk({4'h0, acks}, 8'h07);
    chk({1'b0, pot}, 8'h25);
    chk({7'h00, nv_busy_out}, 8'h01);
    id_only(DEVICE_TYPE_CODE);
    chk({7'h00, k}, 8'h00);
    wait_idle();
    rd(11'h7FF, 1);
    chk(rq[0], 8'h25);
    wr(11'h7FE, 8'h80, 8'h11, 2);
    chk({4'h0, acks}, 8'h0F);
    chk({6'h00, flag, nv_busy_out}, 8'h02);
    chk({1'b0, pot}, 8'h11);
    rd(11'h7FE, 2);
    chk(rq[0], 8'h80);
    chk(rq[1], 8'h11);
    wr(11'h5F0, 8'hA3, 8'h5C, 2);
    @(posedge ref_clk_in);
    ce_in <= 1'b0;
    repeat (300) @(posedge ref_clk_in);
    chk({7'h00, nv_busy_out}, 8'h01);
    ce_in <= 1'b1;
    wait_idle();
    rd(11'h5F0, 2);
    chk(rq[0], 8'hA3);
    chk(rq[1], 8'h5C);
    id_only(~DEVICE_TYPE_CODE);
    chk({7'h00, k}, 8'h00);
    @(posedge ref_clk_in);
    wp_n_in <= 1'b0;
    wr(11'h7FF, 8'h55, 8'h00, 1);
    chk({4'h0, acks}, 8'h03);
    chk({1'b0, pot}, 8'h11);
    @(posedge ref_clk_in);
    wp_n_in <= 1'b1;
    do_reset();
    wait_idle();
    chk({1'b0, pot}, 8'h25);
    chk({7'h00, flag}, 8'h00);
    report_and_stop();
  end
endmodule
